// [asd_pkg.sv]
// Package for the add/subtract datapath: operation codes, register indices, widths.
// Assumes a 32-bit core with sixteen general registers, stack pointer 13, program counter 15.
package asd_pkg;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 4;
  localparam int unsigned IMM_W = 12;
  localparam logic [REG_W-1:0] SP_IDX = 4'hD;
  localparam logic [REG_W-1:0] PC_IDX = 4'hF;
  localparam logic [DATA_W-1:0] RESULT_RST = 32'h0000_0000;
  localparam logic [3:0] FLAGS_RST = 4'h0;
  localparam logic [1:0] PC_ALIGN_MASK = 2'h0;
  localparam int unsigned FLAG_N = 3;
  localparam int unsigned FLAG_Z = 2;
  localparam int unsigned FLAG_C = 1;
  localparam int unsigned FLAG_V = 0;
  localparam int unsigned LATENCY_CYCLES = 1;

  // Operation selector from the decoder
  typedef enum logic [2:0] {
    ASD_SUM,
    ASD_CARRY_SUM,
    ASD_DIFF,
    ASD_BORROW_DIFF,
    ASD_REV_DIFF,
    ASD_WIDE_SUM,
    ASD_WIDE_DIFF
  } asd_op_t;
endpackage : asd_pkg

// [asd_adder.sv]
// Holds the 32-bit adder with carry-in that all operations share.
// Assumes purely combinational use inside the datapath.
`timescale 1ns/1ps
module asd_adder (
  input wire logic [31:0] a_i,   // First addend
  input wire logic [31:0] b_i,   // Second addend
  input wire logic cin_i,        // Carry in
  output logic [31:0] sum_o,     // Wrapped sum
  output logic cout_o,           // Carry out
  output logic ovf_o             // Signed overflow
);
  logic [32:0] wide;

  // Sum with carry and signed overflow
  always_comb
  begin
    wide = {1'b0, a_i} + {1'b0, b_i} + {32'h0000_0000, cin_i};
    sum_o = wide[31:0];
    cout_o = wide[32];
    ovf_o = (a_i[31] == b_i[31]) && (wide[31] != a_i[31]);
  end
endmodule : asd_adder

// [asd_flag_calc.sv]
// Holds the negative and zero flag computation on a result word.
// Assumes the carry and overflow bits come from the adder.
`timescale 1ns/1ps
module asd_flag_calc (
  input wire logic [31:0] res_i,  // Result word
  input wire logic cout_i,        // Carry from adder
  input wire logic ovf_i,         // Overflow from adder
  output logic [3:0] nzcv_o       // Flags N Z C V
);
  // Pack flags
  always_comb
  begin
    nzcv_o = {res_i[31], (res_i == 32'h0000_0000), cout_i, ovf_i};
  end
endmodule : asd_flag_calc

// [asd_datapath.sv]
// Holds the add/subtract datapath: operand selection, shared adder, write-back and flags.
// Assumes the decoder supplies register values and legal encodings in one cycle.
`timescale 1ns/1ps
// Functional notes
// - Sum adds first operand and operand/immediate
// - Carry sum adds carry flag in
// - Difference subtracts operand or immediate
// - Borrow difference subtracts one more when carry clear
// - Reversed difference is operand minus first
// - Twelve-bit immediate only plain forms, no flags
// - Missing destination means first operand register
// - Flags change only with update suffix
// - Wide forms equal immediate sum/difference
// - Program counter source has low bits cleared
// - Branch via PC-plus-register clears bit zero
// - Suffix sets N Z C V from result, except on wide forms
module asd_datapath (
  input wire logic core_clk_i,                    // Core clock 250 MHz
  input wire logic rst_i,                         // Async reset, active high
  input wire logic issue_i,                       // One-cycle operation request
  input wire asd_pkg::asd_op_t op_i,              // Operation selector
  input wire logic use_imm_i,                     // Take the twelve-bit immediate
  input wire logic [11:0] twelve_bit_immediate_i,                // Twelve-bit immediate
  input wire logic set_flags_i,                   // Flag update suffix present
  input wire logic dest_given_i,                  // Destination encoded
  input wire logic [3:0] dest_idx_i,              // Destination register index
  input wire logic [3:0] first_idx_i,             // First operand register index
  input wire logic [31:0] first_val_i,            // First operand register value
  input wire logic [31:0] flex_val_i,             // Flexible second operand value
  input wire logic [3:0] flags_i,                 // Current flags N Z C V
  output logic wr_en_o,                           // Register write pulse
  output logic [3:0] wr_idx_o,                    // Register written
  output logic [31:0] wr_data_o,                  // Data written
  output logic branch_o,                          // Branch pulse to wr_data_o
  output logic flags_we_o,                        // Flag write pulse
  output logic [3:0] flags_o                      // New flags N Z C V
);
  import asd_pkg::*;

  logic [31:0] op_a;
  logic [31:0] op_b;
  logic cin;
  logic [31:0] add_sum;
  logic add_cout;
  logic add_ovf;
  logic [3:0] calc_flags;
  logic [31:0] first_eff;
  logic [31:0] second_eff;
  logic imm_ok;
  logic [3:0] dest_eff;
  logic next_wr_en;
  logic [3:0] next_wr_idx;
  logic [31:0] next_wr_data;
  logic next_branch;
  logic next_flags_we;
  logic [3:0] next_flags;

  // Operand selection and adder input shaping
  always_comb
  begin
    first_eff = first_val_i;
    if (first_idx_i == PC_IDX)
    begin
      first_eff = {first_val_i[31:2], PC_ALIGN_MASK};
    end
    // Immediate only for plain and wide forms, never flagged
    imm_ok = use_imm_i && !set_flags_i;
    if (op_i == ASD_WIDE_SUM || op_i == ASD_WIDE_DIFF)
    begin
      imm_ok = 1'b1;
    end
    second_eff = imm_ok ? {20'h00000, twelve_bit_immediate_i} : flex_val_i;
    op_a = first_eff;
    op_b = second_eff;
    cin = 1'b0;
    case (op_i)
      ASD_SUM, ASD_WIDE_SUM:
      begin
        op_b = second_eff;
      end
      ASD_CARRY_SUM:
      begin
        op_b = flex_val_i;
        cin = flags_i[FLAG_C];
      end
      ASD_DIFF, ASD_WIDE_DIFF:
      begin
        op_b = ~second_eff;
        cin = 1'b1;
      end
      ASD_BORROW_DIFF:
      begin
        op_b = ~flex_val_i;
        cin = flags_i[FLAG_C];
      end
      ASD_REV_DIFF:
      begin
        op_a = flex_val_i;
        op_b = ~first_eff;
        cin = 1'b1;
      end
      default:
      begin
        op_b = second_eff;
      end
    endcase
  end

  asd_adder u_adder (
    .a_i(op_a),
    .b_i(op_b),
    .cin_i(cin),
    .sum_o(add_sum),
    .cout_o(add_cout),
    .ovf_o(add_ovf)
  );

  asd_flag_calc u_flags (
    .res_i(add_sum),
    .cout_i(add_cout),
    .ovf_i(add_ovf),
    .nzcv_o(calc_flags)
  );

  // Write-back, branch and flag next values
  always_comb
  begin
    dest_eff = dest_given_i ? dest_idx_i : first_idx_i;
    next_wr_en = 1'b0;
    next_wr_idx = wr_idx_o;
    next_wr_data = wr_data_o;
    next_branch = 1'b0;
    next_flags_we = 1'b0;
    next_flags = flags_o;
    if (issue_i)
    begin
      next_wr_idx = dest_eff;
      if (dest_eff == PC_IDX)
      begin
        // PC-plus-register form, for the caller side
        next_wr_data = {add_sum[31:1], 1'b0};
        next_branch = 1'b1;
      end
      else
      begin
        next_wr_data = add_sum;
        next_wr_en = 1'b1;
      end
      if (set_flags_i && !(op_i == ASD_WIDE_SUM || op_i == ASD_WIDE_DIFF))
      begin
        next_flags_we = 1'b1;
        next_flags = calc_flags;
      end
    end
  end

  // Output registers
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_en_o <= 1'b0;
      wr_idx_o <= 4'h0;
      wr_data_o <= RESULT_RST;
      branch_o <= 1'b0;
      flags_we_o <= 1'b0;
      flags_o <= FLAGS_RST;
    end
    else
    begin
      wr_en_o <= next_wr_en;
      wr_idx_o <= next_wr_idx;
      wr_data_o <= next_wr_data;
      branch_o <= next_branch;
      flags_we_o <= next_flags_we;
      flags_o <= next_flags;
    end
  end

  // Checks on the registered answer
  sequence s_plain_sum;
    issue_i && op_i == ASD_SUM && !use_imm_i && first_idx_i != PC_IDX && dest_given_i
      && dest_idx_i != PC_IDX;
  endsequence

  a_plain_sum_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_plain_sum |=> wr_en_o && wr_data_o == $past(first_val_i) + $past(flex_val_i))
    else $error("sum result wrong");

  a_carry_sum_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_CARRY_SUM && first_idx_i != PC_IDX && dest_idx_i != PC_IDX
      && dest_given_i |=> wr_data_o == $past(first_val_i) + $past(flex_val_i)
      + {31'h0, $past(flags_i[1])})
    else $error("carry sum result wrong");

  a_diff_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_DIFF && use_imm_i && !set_flags_i && first_idx_i != PC_IDX
      && dest_given_i && dest_idx_i != PC_IDX
      |=> wr_data_o == $past(first_val_i) - {20'h00000, $past(twelve_bit_immediate_i)})
    else $error("immediate difference wrong");

  a_borrow_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_BORROW_DIFF && !flags_i[1] && first_idx_i != PC_IDX
      && dest_given_i && dest_idx_i != PC_IDX
      |=> wr_data_o == $past(first_val_i) - $past(flex_val_i) - 32'h0000_0001)
    else $error("borrow difference wrong");

  a_rev_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_REV_DIFF && first_idx_i != PC_IDX && dest_given_i
      && dest_idx_i != PC_IDX |=> wr_data_o == $past(flex_val_i) - $past(first_val_i))
    else $error("reversed difference wrong");

  a_default_dest: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && !dest_given_i && first_idx_i != PC_IDX |=> wr_en_o
      && wr_idx_o == $past(first_idx_i))
    else $error("default destination wrong");

  a_flags_hold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !(issue_i && set_flags_i) |=> !flags_we_o && $stable(flags_o))
    else $error("flags changed without suffix");

  a_branch_even: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && dest_given_i && dest_idx_i == PC_IDX |=> branch_o && !wr_en_o
      && wr_data_o[0] == 1'b0 ##1 (!branch_o || $past(issue_i)))
    else $error("branch target not even");

  a_pc_aligned: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_SUM && use_imm_i && !set_flags_i && first_idx_i == PC_IDX
      && dest_given_i && dest_idx_i != PC_IDX
      |=> wr_data_o == {$past(first_val_i[31:2]), 2'h0} + {20'h00000, $past(twelve_bit_immediate_i)})
    else $error("program counter not aligned");

  a_zero_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && set_flags_i && op_i == ASD_DIFF && !use_imm_i && first_idx_i != PC_IDX
      && first_val_i == flex_val_i |=> flags_we_o && flags_o == 4'h6)
    else $error("equal difference flags wrong");

  // Pulse, hold and destination behaviour after requests and idle cycles
  sequence s_idle_cycle;
    !issue_i;
  endsequence

  a_idle_no_pulse: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_idle_cycle |=> !wr_en_o && !branch_o && !flags_we_o)
    else $error("pulse without request");

  a_result_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_idle_cycle |=> $stable(wr_data_o) && $stable(wr_idx_o))
    else $error("result moved without request");

  a_one_answer: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i |=> wr_en_o != branch_o)
    else $error("write and branch not exclusive");

  a_given_dest: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && dest_given_i && dest_idx_i != PC_IDX |=> wr_en_o && wr_idx_o == $past(dest_idx_i))
    else $error("given destination wrong");

  // Result and flag values on the remaining forms
  a_wide_sum_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_WIDE_SUM && first_idx_i != PC_IDX && dest_given_i
      && dest_idx_i != PC_IDX
      |=> wr_data_o == $past(first_val_i) + {20'h00000, $past(twelve_bit_immediate_i)})
    else $error("wide sum result wrong");

  a_wide_no_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && (op_i == ASD_WIDE_SUM || op_i == ASD_WIDE_DIFF) |=> !flags_we_o)
    else $error("wide form wrote flags");

  a_flagged_imm_swap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_DIFF && use_imm_i && set_flags_i && first_idx_i != PC_IDX
      && dest_given_i && dest_idx_i != PC_IDX
      |=> wr_data_o == $past(first_val_i) - $past(flex_val_i))
    else $error("flagged immediate not replaced");

  a_borrow_carry_set: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && op_i == ASD_BORROW_DIFF && flags_i[FLAG_C] && first_idx_i != PC_IDX
      && dest_given_i && dest_idx_i != PC_IDX
      |=> wr_data_o == $past(first_val_i) - $past(flex_val_i))
    else $error("borrow difference with carry wrong");

  a_no_borrow_carry: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && set_flags_i && op_i == ASD_DIFF && first_idx_i != PC_IDX
      |=> flags_we_o && flags_o[FLAG_C] == ($past(first_val_i) >= $past(flex_val_i)))
    else $error("carry is not no-borrow");

  a_sum_carry_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && set_flags_i && op_i == ASD_SUM && first_idx_i != PC_IDX
      |=> flags_o[FLAG_C] == (({1'b0, $past(first_val_i)} + {1'b0, $past(flex_val_i)})
      > 33'h0_FFFF_FFFF))
    else $error("sum carry flag wrong");

  a_sign_zero_flags: assert property (@(posedge core_clk_i) disable iff (rst_i)
    issue_i && set_flags_i && !(op_i == ASD_WIDE_SUM || op_i == ASD_WIDE_DIFF)
      && (dest_given_i ? dest_idx_i : first_idx_i) != PC_IDX
      |=> flags_o[FLAG_N] == wr_data_o[31] && flags_o[FLAG_Z] == (wr_data_o == 32'h0000_0000))
    else $error("sign or zero flag wrong");
endmodule : asd_datapath

// [asd_flag_model.sv]
// Flag register model standing on the far side of the add/subtract datapath.
// Assumes the datapath's flag write pulse and the one core clock.
`timescale 1ns/1ps
module asd_flag_model (
  input wire logic core_clk_i,    // Core clock
  input wire logic rst_i,         // Async reset, active high
  input wire logic we_i,          // Flag write pulse
  input wire logic [3:0] nzcv_i,  // New flags
  output logic [3:0] nzcv_o       // Held flags
);
  logic [3:0] next_nzcv;

  // Takes new flags only on a write pulse, so the carry chain sees them next
  always_comb
  begin
    next_nzcv = we_i ? nzcv_i : nzcv_o;
  end

  // Registers the flags
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      nzcv_o <= 4'h0;
    end
    else
    begin
      nzcv_o <= next_nzcv;
    end
  end
endmodule : asd_flag_model

// [testbench.sv]
// Self-checking bench for the add/subtract datapath with a flag register model.
// Assumes one result pulse one cycle after each issue.
`timescale 1ns/1ps
module testbench;
  import asd_pkg::*;
  typedef struct packed {
    logic br;
    logic [3:0] idx;
    logic [31:0] data;
    logic fwe;
    logic [3:0] nzcv;
  } asd_exp_t;
  logic core_clk_i, rst_i, issue_i, use_imm_i, set_flags_i, dest_given_i;
  asd_op_t op_i;
  logic [11:0] twelve_bit_immediate_i;
  logic [3:0] dest_idx_i, first_idx_i, flags_i, wr_idx_o, flags_o, sh;
  logic [31:0] first_val_i, flex_val_i, wr_data_o, seed;
  logic wr_en_o, branch_o, flags_we_o;
  logic [31:0] pv [4] = '{32'hFFFFFFFF, 32'h80000000, 32'h0, 32'h1};
  asd_exp_t q[$];
  int n_errors, n_checks;

  asd_datapath dut (.core_clk_i, .rst_i, .issue_i, .op_i, .use_imm_i, .twelve_bit_immediate_i, .set_flags_i,
    .dest_given_i, .dest_idx_i, .first_idx_i, .first_val_i, .flex_val_i, .flags_i, .wr_en_o,
    .wr_idx_o, .wr_data_o, .branch_o, .flags_we_o, .flags_o);
  asd_flag_model partner (.core_clk_i, .rst_i, .we_i(flags_we_o), .nzcv_i(flags_o),
    .nzcv_o(flags_i));

  // Clock at 4 ns
  initial
  begin
    core_clk_i = 1'h0;
    forever #2 core_clk_i = ~core_clk_i;
  end

  // Xorshift source
  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  // Predicts the result from the operands and the flags held in the bench copy sh
  function automatic asd_exp_t predict(asd_op_t op, logic ui, logic [11:0] imm, logic sf,
    logic dg, logic [3:0] d, logic [3:0] f, logic [31:0] a, logic [31:0] b);
    logic [32:0] s;
    logic [31:0] x, y;
    logic cin, wide;
    asd_exp_t e;
    wide = (op == ASD_WIDE_SUM) || (op == ASD_WIDE_DIFF);
    x = (f == PC_IDX) ? {a[31:2], 2'h0} : a;
    y = (wide || (ui && !sf && (op == ASD_SUM || op == ASD_DIFF))) ? {20'h0, imm} : b;
    cin = (op == ASD_CARRY_SUM) ? sh[FLAG_C] : 1'h0;
    if (op == ASD_DIFF || op == ASD_WIDE_DIFF || op == ASD_BORROW_DIFF)
    begin
      y = ~y;
      cin = (op == ASD_BORROW_DIFF) ? sh[FLAG_C] : 1'h1;
    end
    if (op == ASD_REV_DIFF)
    begin
      s[31:0] = x;
      x = y;
      y = ~s[31:0];
      cin = 1'h1;
    end
    s = {1'h0, x} + {1'h0, y} + {32'h0, cin};
    e.idx = dg ? d : f;
    e.br = (e.idx == PC_IDX);
    e.data = e.br ? {s[31:1], 1'h0} : s[31:0];
    e.fwe = sf && !wide;
    e.nzcv = {s[31], s[31:0] == 32'h0, s[32], (x[31] == y[31]) && (s[31] != x[31])};
    return e;
  endfunction : predict

  task automatic issue(asd_op_t op, logic ui, logic [11:0] imm, logic sf, logic dg,
    logic [3:0] d, logic [3:0] f, logic [31:0] a, logic [31:0] b);
    asd_exp_t e;
    e = predict(op, ui, imm, sf, dg, d, f, a, b);
    q.push_back(e);
    {issue_i, use_imm_i, twelve_bit_immediate_i, set_flags_i} <= {1'h1, ui, imm, sf};
    op_i <= op;
    {dest_given_i, dest_idx_i, first_idx_i, first_val_i, flex_val_i} <= {dg, d, f, a, b};
    @(posedge core_clk_i);
    if (e.fwe)
    begin
      sh = e.nzcv;
      issue_i <= 1'h0;
      @(posedge core_clk_i);
    end
  endtask : issue

  task automatic chk(string nm, logic [31:0] ex, logic [31:0] got);
    n_checks++;
    if (ex !== got)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  // Compares each result pulse with the oldest note
  always @(negedge core_clk_i)
  begin
    if ((wr_en_o | branch_o | flags_we_o) === 1'h1)
    begin
      asd_exp_t e;
      e = (q.size() > 0) ? q.pop_front() : '0;
      chk("branch", {31'h0, e.br}, {31'h0, branch_o});
      chk("write", {31'h0, !e.br}, {31'h0, wr_en_o});
      chk("index", {28'h0, e.idx}, {28'h0, wr_idx_o});
      chk("data", e.data, wr_data_o);
      chk("flag_we", {31'h0, e.fwe}, {31'h0, flags_we_o});
      if (e.fwe)
        chk("flags", {28'h0, e.nzcv}, {28'h0, flags_o});
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // Watchdog
  initial
  begin
    #60000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    logic [31:0] r;
    {issue_i, use_imm_i, set_flags_i, dest_given_i, twelve_bit_immediate_i, dest_idx_i, first_idx_i} = '0;
    {first_val_i, flex_val_i, sh, n_errors, n_checks} = '0;
    op_i = ASD_SUM;
    seed = 32'h42FB065C;
    rst_i = 1'h1;
    repeat (12) @(posedge core_clk_i);
    rst_i <= 1'h0;
    @(posedge core_clk_i);
    issue(ASD_SUM, 0, 0, 1, 1, 4'h2, 4'h1, 32'h5, 32'h3);
    $display("test walk done");
    // Every operation against boundary and random operand pairs
    for (int j = 0; j < 5; j++)
      for (int i = 0; i < 7; i++)
      begin
        r = nxt();
        issue(asd_op_t'(i), 0, r[11:0], 1, 1, 4'h3, 4'h4,
          j < 4 ? pv[j] : nxt(), pv[(j + i) % 4]);
      end
    $display("test operations done");
    issue(ASD_SUM, 1, 12'hFFF, 0, 1, 4'h5, 4'h6, 32'hFFFFF001, nxt());
    issue(ASD_DIFF, 1, 12'hFFF, 1, 1, 4'h5, 4'h6, 32'h10, 32'h11);
    issue(ASD_DIFF, 0, 0, 0, 0, 4'h9, 4'h7, nxt(), nxt());
    issue(ASD_SUM, 1, 12'h004, 0, 1, 4'h2, PC_IDX, 32'h1003, 32'h0);
    issue(ASD_SUM, 0, 0, 0, 1, PC_IDX, PC_IDX, 32'h2002, 32'h101);
    issue(ASD_DIFF, 1, 12'h010, 0, 1, SP_IDX, SP_IDX, 32'h400, 32'h0);
    r = nxt();
    issue(ASD_DIFF, 0, 0, 1, 1, 4'h8, 4'h9, r, r);
    $display("test operand forms done");
    // Back-to-back random traffic without flag updates
    for (int i = 0; i < 40; i++)
    begin
      r = nxt();
      issue(asd_op_t'(r[2:0] % 7), r[3], r[15:4], 0, r[16], {1'h0, r[19:17]},
        {1'h0, r[22:20]}, nxt(), nxt());
    end
    issue_i <= 1'h0;
    repeat (3) @(posedge core_clk_i);
    chk("pending", 32'h0, 32'(q.size()));
    $display("test random done");
    complete_run();
  end
endmodule : testbench
